// >>> rtl/mmbs_pkg.sv
// Package with address map constants and carrier types for the memory-map block
package mmbs_pkg;
	// Program flash entry map
	localparam logic [13:0] MMBS_RESET_VEC = 14'h0000;
	localparam logic [13:0] MMBS_SUPPLY_VEC = 14'h0004;
	localparam logic [13:0] MMBS_DIG_VEC_BASE = 14'h0008;
	localparam logic [13:0] MMBS_ANA_VEC_BASE = 14'h0028;
	localparam logic [13:0] MMBS_GPIO_VEC = 14'h0038;
	localparam logic [13:0] MMBS_SLEEP_VEC = 14'h003C;
	localparam logic [13:0] MMBS_USER_START = 14'h0040;
	localparam logic [13:0] MMBS_FLASH_MAX = 14'h3FFF;
	localparam int MMBS_VEC_SHIFT = 2;
	localparam int MMBS_NUM_DIG = 8;
	localparam int MMBS_NUM_ANA = 4;
	localparam int MMBS_NUM_SRC = 15;
	// Source index layout: 0 supply, 1..8 digital, 9..12 analog, 13 gpio, 14 sleep
	localparam logic [3:0] MMBS_SRC_SUPPLY = 4'h0;
	localparam logic [3:0] MMBS_SRC_DIG0 = 4'h1;
	localparam logic [3:0] MMBS_SRC_ANA0 = 4'h9;
	localparam logic [3:0] MMBS_SRC_GPIO = 4'hD;
	localparam logic [3:0] MMBS_SRC_SLEEP = 4'hE;
	// Data RAM stack
	localparam logic [7:0] MMBS_SP_RESET = 8'h00;
	localparam logic [7:0] MMBS_SP_STEP = 8'h01;
	// Register banks
	localparam logic [7:0] MMBS_SHARED_LO = 8'h71;
	localparam logic [7:0] MMBS_SHARED_HI = 8'h9F;
	localparam logic MMBS_BANK0 = 1'b0;
	localparam logic MMBS_BANK1 = 1'b1;

	// Stack request from the core
	typedef struct packed {
		logic push;
		logic pop;
		logic load;
		logic [7:0] load_val;
	} mmbs_stack_req_type;

	// Register access request from the core
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mmbs_reg_req_type;

	// Decoded register access toward the banks
	typedef struct packed {
		logic valid;
		logic write;
		logic bank;
		logic shared_hit;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mmbs_reg_sel_type;
endpackage

// >>> rtl/mmbs_vector_rom.sv
// Combinational entry-address lookup for interrupt sources
`timescale 1ns/1ps
module mmbs_vector_rom import mmbs_pkg::*; (
	// Source select
	input wire logic [3:0] src,
	// Entry address
	output logic [13:0] vec
);
	// Digital and analog slots are four bytes apart from their bases
	wire logic [13:0] dig_off = {10'h000, src - MMBS_SRC_DIG0} << MMBS_VEC_SHIFT;
	wire logic [13:0] ana_off = {10'h000, src - MMBS_SRC_ANA0} << MMBS_VEC_SHIFT;
	wire logic is_dig = (src >= MMBS_SRC_DIG0) && (src < MMBS_SRC_ANA0);
	wire logic is_ana = (src >= MMBS_SRC_ANA0) && (src < MMBS_SRC_GPIO);

	// Fixed table select; unknown sources fall back to reset entry
	assign vec = (src == MMBS_SRC_SUPPLY) ? MMBS_SUPPLY_VEC : // RULE1
		is_dig ? (MMBS_DIG_VEC_BASE + dig_off) : // RULE2
		is_ana ? (MMBS_ANA_VEC_BASE + ana_off) : // RULE3
		(src == MMBS_SRC_GPIO) ? MMBS_GPIO_VEC : // RULE4
		(src == MMBS_SRC_SLEEP) ? MMBS_SLEEP_VEC : // RULE4
		MMBS_RESET_VEC;
endmodule

// >>> rtl/mmbs_bank_decode.sv
// Register bank decode with shared window
`timescale 1ns/1ps
module mmbs_bank_decode import mmbs_pkg::*; (
	// Core side
	input wire mmbs_reg_req_type req,
	input wire logic bank_select_flag,
	// Bank side
	output mmbs_reg_sel_type sel
);
	// Shared window ignores the flag and always lands in bank 0
	wire logic shared_hit = (req.addr >= MMBS_SHARED_LO) && (req.addr <= MMBS_SHARED_HI); // RULE11
	wire logic bank_eff = shared_hit ? MMBS_BANK0 : bank_select_flag; // RULE10

	assign sel.valid = req.valid;
	assign sel.write = req.write;
	assign sel.bank = bank_eff;
	assign sel.shared_hit = shared_hit;
	assign sel.addr = req.addr; // RULE9
	assign sel.wdata = req.wdata;
endmodule

// >>> rtl/mmbs_memory_map.sv
// Top level: program entry sequencing, data stack pointer and register bank select
// Behaviour
// RULE1: Reset enters at 0x0000 and the supply-monitor interrupt enters at 0x0004.
// RULE2: The eight digital block entries sit at 0x0008 to 0x0024, four basic then four comm, four bytes apart.
// RULE3: The four analog column entries sit at 0x0028 to 0x0034 in column order, four bytes apart.
// RULE4: The pin interrupt enters at 0x0038 and the sleep timer at 0x003C.
// RULE5: User code starts at 0x0040 right after the entry table.
// RULE6: Program addresses never exceed 0x3FFF; the usable top depends on the variant.
// RULE7: Each push moves the stack pointer to a higher address.
// RULE8: A stack pointer step past 0xFF wraps silently to 0x00.
// RULE9: Two register banks of 256 addresses each are decoded.
// RULE10: The bank-select flag picks bank 0 when clear and bank 1 when set.
// RULE11: Addresses 0x71 to 0x9F reach the same registers from either bank.
// RULE12: Software never writes undefined register addresses.
// RULE13: Software writes zero into unused and reserved bits.
// RULE14: A taken interrupt jumps to its fixed four-byte entry slot.
`timescale 1ns/1ps
module mmbs_memory_map import mmbs_pkg::*; #(
	parameter logic [13:0] FLASH_TOP = 14'h3FFF
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Interrupt entry request from the core
	input wire logic irq_take,
	input wire logic [3:0] irq_src,
	// Sequential fetch and jump
	input wire logic fetch_step,
	input wire logic jump_valid,
	input wire logic [13:0] jump_addr,
	// Stack control
	input wire mmbs_stack_req_type stack_req,
	// Flags register bank-select bit
	input wire logic bank_select_flag,
	// Register access from the core
	input wire mmbs_reg_req_type reg_req,
	// Program counter and stack pointer
	output logic [13:0] pc,
	output logic pc_in_user,
	output logic [7:0] sp,
	output logic sp_wrapped,
	// Register bank access
	output mmbs_reg_sel_type reg_sel
);
	logic [13:0] pc_reg, pc_next;
	logic [7:0] sp_reg, sp_next;
	logic sp_wrap_reg, sp_wrap_next;
	logic user_reg, user_next;
	mmbs_reg_sel_type sel_reg;
	logic [13:0] vec_addr;
	mmbs_reg_sel_type sel_comb;

	// Entry table lookup
	mmbs_vector_rom u_vec (
		.src(irq_src),
		.vec(vec_addr)
	);

	// Bank decode
	mmbs_bank_decode u_dec (
		.req(reg_req),
		.bank_select_flag(bank_select_flag),
		.sel(sel_comb)
	);

	// Program counter: clamp top so the map never runs past the variant size
	wire logic [13:0] flash_top = (FLASH_TOP > MMBS_FLASH_MAX) ? MMBS_FLASH_MAX : FLASH_TOP; // RULE6
	wire logic [13:0] pc_inc = (pc_reg >= flash_top) ? MMBS_RESET_VEC : pc_reg + 14'h0001; // RULE6
	wire logic [13:0] jump_cl = (jump_addr > flash_top) ? flash_top : jump_addr; // RULE6

	// Interrupt wins over jump, jump over sequential step
	assign pc_next = irq_take ? vec_addr : // RULE14
		jump_valid ? jump_cl :
		fetch_step ? pc_inc : pc_reg;
	assign user_next = (pc_next >= MMBS_USER_START); // RULE5

	// Stack pointer: 9-bit add cut to its low 8 bits wraps naturally, no error raised
	wire logic [8:0] sp_up = {1'b0, sp_reg} + {1'b0, MMBS_SP_STEP}; // RULE7
	wire logic [7:0] sp_dn = sp_reg - MMBS_SP_STEP;
	assign sp_next = stack_req.load ? stack_req.load_val :
		stack_req.push ? sp_up[7:0] : // RULE8
		stack_req.pop ? sp_dn : sp_reg;
	// Wrap marker is a one-cycle pulse for debug visibility
	assign sp_wrap_next = !stack_req.load && stack_req.push && sp_up[8]; // RULE8

	// Program counter starts at the reset entry
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pc_reg <= MMBS_RESET_VEC; // RULE1
			user_reg <= 1'b0;
		end else begin
			pc_reg <= pc_next;
			user_reg <= user_next;
		end
	end

	// Stack pointer register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sp_reg <= MMBS_SP_RESET;
			sp_wrap_reg <= 1'b0;
		end else begin
			sp_reg <= sp_next;
			sp_wrap_reg <= sp_wrap_next;
		end
	end

	// Registered bank access; undefined writes are trusted not to occur
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sel_reg <= '0;
		end else begin
			sel_reg <= sel_comb; // RULE10
		end
	end

	assign pc = pc_reg;
	assign pc_in_user = user_reg;
	assign sp = sp_reg;
	assign sp_wrapped = sp_wrap_reg;
	assign reg_sel = sel_reg;
endmodule

// >>> verification/mmbs_memory_map_props.sv
// Port checker for the memory-map block
`timescale 1ns/1ps
module mmbs_memory_map_props import mmbs_pkg::*; #(parameter logic [13:0] FLASH_TOP = 14'h3FFF) (
	// Inputs and outputs watched
	input wire logic sys_clk, resetn, irq_take, bank_select_flag, pc_in_user, sp_wrapped,
	input wire logic [3:0] irq_src,
	input wire logic [13:0] pc,
	input wire logic [7:0] sp,
	input wire mmbs_stack_req_type stack_req,
	input wire mmbs_reg_req_type reg_req,
	input wire mmbs_reg_sel_type reg_sel
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Taken interrupt from a source range
	sequence s_irq(lo, hi);
		irq_take && irq_src >= lo && irq_src <= hi;
	endsequence
	sequence s_push;
		stack_req.push && !stack_req.load;
	endsequence
	vec_supply_a: assert property (s_irq(0, 0) |=> pc == 14'h0004) else $error("supply entry");
	vec_dig_a: assert property (s_irq(1, 8) |=> pc == 14'h0008 + 4 * ($past(irq_src) - 1)) else $error("dig");
	vec_ana_a: assert property (s_irq(9, 12) |=> pc == 14'h0028 + 4 * ($past(irq_src) - 9)) else $error("ana");
	vec_pin_a: assert property (s_irq(13, 14) |=> pc == 14'h0038 + 4 * ($past(irq_src) - 13)) else $error("pin");
	user_flag_a: assert property (pc_in_user == (pc >= 14'h0040)) else $error("user flag");
	flash_top_a: assert property (pc <= FLASH_TOP) else $error("pc above top");
	sp_up_a: assert property (s_push |=> sp == $past(sp) + 8'h01) else $error("push");
	sp_wrap_a: assert property (s_push ##0 sp == 8'hFF |=> sp == 8'h00 && sp_wrapped ##1 !sp_wrapped) else $error("wrap");
	sp_load_a: assert property (stack_req.load |=> sp == $past(stack_req.load_val)) else $error("load");
	sp_down_a: assert property (stack_req.pop && !stack_req.push && !stack_req.load
		|=> sp == $past(sp) - 8'h01 && !sp_wrapped) else $error("pop");
	sel_pass_a: assert property (reg_req.valid |=> reg_sel.valid && reg_sel.write == $past(reg_req.write)
		&& reg_sel.wdata == $past(reg_req.wdata)) else $error("pass");
	bank_pick_a: assert property (reg_req.valid && (reg_req.addr < 8'h71 || reg_req.addr > 8'h9F)
		|=> reg_sel.bank == $past(bank_select_flag) && reg_sel.addr == $past(reg_req.addr)) else $error("bank");
	shared_win_a: assert property (reg_req.valid && reg_req.addr inside {[8'h71:8'h9F]}
		|=> reg_sel.shared_hit && reg_sel.bank == 1'b0) else $error("shared");
endmodule
bind mmbs_memory_map mmbs_memory_map_props #(.FLASH_TOP(FLASH_TOP)) i_props (.*);

// >>> verification/mmbs_core_model.sv
// Core-side request source for interrupt, stack and register paths
`timescale 1ns/1ps
module mmbs_core_model import mmbs_pkg::*; (
	input wire logic sys_clk,
	output logic irq_take, bank_select_flag,
	output logic [3:0] irq_src,
	output mmbs_stack_req_type stack_req,
	output mmbs_reg_req_type reg_req
);
	initial {irq_take, bank_select_flag, irq_src, stack_req, reg_req} = '0;
	// Released source and address fields show inverted values so stale data cannot pass; stack requests release to zero
	task automatic irq(input logic [3:0] s);
		@(posedge sys_clk) {irq_take, irq_src} <= {1'b1, s};
		@(posedge sys_clk) {irq_take, irq_src} <= {1'b0, ~s};
	endtask
	task automatic stk(input logic ld, input logic [7:0] v, input int n);
		@(posedge sys_clk) stack_req <= '{push: !ld, pop: 1'b0, load: ld, load_val: v};
		repeat (n) @(posedge sys_clk);
		stack_req <= '0;
	endtask
	// Single pop, released at the next edge
	task automatic pop1;
		@(posedge sys_clk) stack_req <= '{push: 1'b0, pop: 1'b1, load: 1'b0, load_val: 8'h00};
		@(posedge sys_clk) stack_req <= '0;
	endtask
	// Reads only, zero data: no reserved place is ever written
	task automatic acc(input logic [7:0] a, input logic f);
		@(posedge sys_clk) {reg_req, bank_select_flag} <= {1'b1, 1'b0, a, 8'h00, f};
		@(posedge sys_clk) reg_req <= {1'b0, 1'b0, ~a, 8'h00};
	endtask
endmodule

// >>> verification/mmbs_memory_map_tb_top.sv
// Self-checking testbench for the memory-map block
`timescale 1ns/1ps
module mmbs_memory_map_tb_top import mmbs_pkg::*; ;
	logic sys_clk = 1'b0, resetn = 1'b0, fetch_step = 1'b0, jump_valid = 1'b0;
	logic irq_take, bank_select_flag, pc_in_user, sp_wrapped;
	logic [3:0] irq_src;
	logic [13:0] pc, jump_addr = '0;
	logic [7:0] sp;
	mmbs_stack_req_type stack_req;
	mmbs_reg_req_type reg_req;
	mmbs_reg_sel_type reg_sel;
	int n_fail = 0, checks_done = 0;
	// Smaller variant so the top clamp and the wrap really bite
	localparam logic [13:0] FLASH_TOP_TB = 14'h0FFF;
	initial forever #4 sys_clk = ~sys_clk;
	mmbs_core_model i_core (.*);
	mmbs_memory_map #(.FLASH_TOP(FLASH_TOP_TB)) i_dut (.*);
	task automatic chk(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic t_vectors;
		#1 chk(pc, 16'h0000);
		for (int s = 0; s < 16; s++) begin
			i_core.irq(4'(s));
			#1 chk(pc, s == 15 ? 16'h0000 : 16'h0004 + 16'(s) * 4);
		end
		$display("vectors done");
	endtask
	task automatic t_flash;
		@(posedge sys_clk) {jump_valid, jump_addr} <= {1'b1, 14'h003F};
		@(posedge sys_clk) jump_addr <= 14'h0040;
		#1 chk(pc_in_user, 0);
		@(posedge sys_clk) jump_addr <= 14'h3FFF;
		#1 chk(pc_in_user, 1);
		@(posedge sys_clk) {jump_valid, fetch_step} <= 2'b01;
		#1 chk(pc, {2'b00, FLASH_TOP_TB});
		@(posedge sys_clk) fetch_step <= 1'b0;
		#1 chk(pc, 16'h0000);
		chk(pc_in_user, 0);
		$display("flash done");
	endtask
	task automatic t_stack;
		i_core.stk(1'b1, 8'hFE, 1);
		i_core.stk(1'b0, 8'h00, 2);
		#1 chk({sp, sp_wrapped}, 16'h0001);
		@(posedge sys_clk) #1 chk(sp_wrapped, 0);
		i_core.stk(1'b0, 8'h00, 1);
		#1 chk(sp, 16'h0001);
		i_core.pop1();
		#1 chk(sp, 16'h0000);
		i_core.pop1();
		#1 chk(sp, 16'h00FF);
		chk(sp_wrapped, 0);
		$display("stack done");
	endtask
	task automatic t_banks;
		logic [7:0] a[4] = '{8'h70, 8'h71, 8'h9F, 8'hA0};
		for (int i = 0; i < 8; i++) begin
			i_core.acc(a[i/2], i[0]);
			#1 chk({reg_sel.addr, reg_sel.bank}, {a[i/2], i[0] & (i < 2 || i > 5)});
			chk(reg_sel.shared_hit, i > 1 && i < 6);
			chk({reg_sel.valid, reg_sel.write, reg_sel.wdata}, 16'h0200);
		end
		@(posedge sys_clk) #1 chk(reg_sel.valid, 0);
		$display("banks done");
	endtask
	// Mid-run reset brings every output back to idle
	task automatic t_reset;
		@(posedge sys_clk) jump_valid <= 1'b1;
		jump_addr <= 14'h0123;
		@(posedge sys_clk) {jump_valid, fetch_step} <= 2'b01;
		@(posedge sys_clk) fetch_step <= 1'b0;
		#1 chk(pc, 16'h0124);
		chk(pc_in_user, 1);
		@(posedge sys_clk) resetn <= 1'b0;
		#1 chk({pc, pc_in_user, sp_wrapped}, 16'h0000);
		chk(sp, 16'h0000);
		chk({reg_sel.valid, reg_sel.bank, reg_sel.shared_hit, reg_sel.addr}, 16'h0000);
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk) #1 chk(pc, 16'h0000);
		$display("reset done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence after a 12-cycle reset
	initial begin
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		t_vectors();
		t_flash();
		t_stack();
		t_banks();
		t_reset();
		finish_test();
	end
	// Run needs about 80 cycles; cut a hang well after that
	initial begin
		#5000;
		n_fail++;
		finish_test();
	end
endmodule
